// File: src/tse_map.svh
// register map, field positions, reset values and timing for the timestamp/event block
// assumes a wishbone slave with 32-bit data and byte addresses
`ifndef TSE_MAP_SVH
`define TSE_MAP_SVH
`define TSE_OFS_CTRL 8'h00
`define TSE_OFS_SNAP_LO 8'h04
`define TSE_OFS_SNAP_HI 8'h08
`define TSE_OFS_RATE 8'h0c
`define TSE_OFS_P6_ID 8'h10
`define TSE_OFS_P6_DATA 8'h14
`define TSE_OFS_P6_TLO 8'h18
`define TSE_OFS_P6_THI 8'h1c
`define TSE_OFS_OV_ID 8'h20
`define TSE_OFS_OV_DATA 8'h24
`define TSE_OFS_OV_TLO 8'h28
`define TSE_OFS_OV_THI 8'h2c
`define TSE_OFS_STAT 8'h30
`define TSE_OFS_MASK 8'h34
`define TSE_OFS_DIV 8'h38
`define TSE_CTRL_LATCH 0
`define TSE_CTRL_CLEAR 1
`define TSE_ST_P6 0
`define TSE_ST_OV 1
`define TSE_CLK_HZ 32'h0ee6b280
`define TSE_DIV_RST 32'h00000000
`define TSE_P6_ID_VAL 16'h9006 // arbitrary value, only has to differ from the overflow id
`define TSE_OV_ID_VAL 16'h9fff // arbitrary value
`endif

// File: src/tse_pkg.sv
// types shared by the timestamp/event block
// assumes nothing beyond a systemverilog compiler
package tse_pkg;
	typedef logic [63:0] tse_stamp_t; // one timestamp value
	typedef enum logic [2:0] {
		TSE_IDLE = 3'b001, // waiting for a bus cycle
		TSE_ACK = 3'b010, // answering
		TSE_REST = 3'b100 // ack dropped, master releases
	} tse_bus_e;
endpackage

// File: src/tse_tick.sv
// tick enable generator for the timestamp counter
// assumes a single clock; divider value comes from a register of the parent
`timescale 1ns/1ns
module tse_tick
	import tse_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] div_i,
	output logic tick_o
);
	logic [31:0] cnt; // cycles since last tick

	// divide by div_i+1; zero ticks every cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt >= div_i) begin
			cnt <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule // tse_tick

// File: src/tse_top.sv
// timestamp counter with latch, clear, tick rate and event capture, wishbone slave
// assumes classic wishbone, synchronous event inputs, one 250 MHz clock
// Contract
// - latch command copies count into snapshot
// - snapshot readable as 64 bits
// - report ticks per second in hertz
// - clear command sets counter to zero
// - line six pulse gives id and data
// - line six pulse records its timestamp
// - overflow gives own id and data
// - overflow records its timestamp
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "tse_map.svh"
module tse_top
	import tse_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pulse6_i,
	input wire logic [31:0] pulse6_data_i,
	input wire logic ovf_i,
	input wire logic [31:0] ovf_data_i,
	output logic irq_o
);
	tse_stamp_t count; // free-running timestamp
	tse_stamp_t snapshot; // latched copy
	tse_stamp_t p6_time; // line six stamp
	tse_stamp_t ov_time; // overflow stamp
	logic [31:0] p6_data; // line six data
	logic [31:0] ov_data; // overflow data
	logic [31:0] div; // tick divider
	logic [1:0] stat; // sticky event bits
	logic [1:0] mask; // interrupt enables
	logic tick; // counter step enable
	logic wr_hit; // write accepted this edge
	logic rd_take; // read request taken this edge
	logic [1:0] stat_clr; // status bits cleared by this write
	tse_bus_e bus_st; // bus handshake state

	// merge written bytes over an old word
	function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// rate from divider; sw sees this in hertz
	// widened by a bit so the largest divider cannot wrap to a divide by zero
	function automatic logic [31:0] rate_of(input logic [31:0] d);
		logic [32:0] q;
		q = {1'b0, `TSE_CLK_HZ} / ({1'b0, d} + 33'h1);
		return q[31:0];
	endfunction

	tse_tick u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div_i(div),
		.tick_o(tick)
	);

	// write takes effect in the ack cycle only
	assign wr_hit = (bus_st == TSE_ACK) && wb_cyc_i && wb_stb_i && wb_we_i;
	// read data is registered on the edge that takes the request
	assign rd_take = (bus_st == TSE_IDLE) && wb_cyc_i && wb_stb_i && !wb_we_i;

	// write-one-to-clear bits, only in the ack cycle of a status write
	assign stat_clr = (wr_hit && wb_adr_i == `TSE_OFS_STAT && wb_sel_i[0])
		? wb_dat_i[1:0] : 2'b00;

	// bus handshake: one wait cycle, ack one cycle, then a rest
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_st <= TSE_IDLE;
		end else begin
			unique case (bus_st)
				TSE_IDLE: begin
					if (wb_cyc_i && wb_stb_i) begin
						bus_st <= TSE_ACK;
					end
				end
				TSE_ACK: begin
					bus_st <= TSE_REST;
				end
				TSE_REST: begin
					bus_st <= TSE_IDLE;
				end
				default: begin
					bus_st <= TSE_IDLE;
				end
			endcase
		end
	end

	// ack register mirrors the ack state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= (bus_st == TSE_IDLE) && wb_cyc_i && wb_stb_i;
		end
	end

	// counter: clear has priority over a tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= 64'h0;
		end else if (wr_hit && wb_adr_i == `TSE_OFS_CTRL && wb_sel_i[0]
			&& wb_dat_i[`TSE_CTRL_CLEAR]) begin
			count <= 64'h0;
		end else if (tick) begin
			count <= count + 64'h1;
		end
	end

	// snapshot on latch command; latch takes count before any same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snapshot <= 64'h0;
		end else if (wr_hit && wb_adr_i == `TSE_OFS_CTRL && wb_sel_i[0]
			&& wb_dat_i[`TSE_CTRL_LATCH]) begin
			snapshot <= count;
		end
	end

	// line six capture: data and stamp in the detect cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p6_time <= 64'h0;
			p6_data <= 32'h0;
		end else if (pulse6_i) begin
			p6_time <= count;
			p6_data <= pulse6_data_i;
		end
	end

	// overflow capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ov_time <= 64'h0;
			ov_data <= 32'h0;
		end else if (ovf_i) begin
			ov_time <= count;
			ov_data <= ovf_data_i;
		end
	end

	// sticky status, write one clears; a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat <= 2'b00;
		end else begin
			stat <= (stat & ~stat_clr) | {ovf_i, pulse6_i};
		end
	end

	// mask and divider registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask <= 2'b00;
			div <= `TSE_DIV_RST;
		end else if (wr_hit) begin
			if (wb_adr_i == `TSE_OFS_MASK && wb_sel_i[0]) begin
				mask <= wb_dat_i[1:0];
			end
			if (wb_adr_i == `TSE_OFS_DIV) begin
				div <= sel_merge(div, wb_dat_i, wb_sel_i);
			end
		end
	end

	// interrupt level from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat & mask);
		end
	end

	// read mux registered with the ack; unmapped reads zero, writes ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (rd_take) begin
			unique case (wb_adr_i)
				`TSE_OFS_SNAP_LO: wb_dat_o <= snapshot[31:0];
				`TSE_OFS_SNAP_HI: wb_dat_o <= snapshot[63:32];
				`TSE_OFS_RATE: wb_dat_o <= rate_of(div);
				`TSE_OFS_P6_ID: wb_dat_o <= {16'h0, `TSE_P6_ID_VAL};
				`TSE_OFS_P6_DATA: wb_dat_o <= p6_data;
				`TSE_OFS_P6_TLO: wb_dat_o <= p6_time[31:0];
				`TSE_OFS_P6_THI: wb_dat_o <= p6_time[63:32];
				`TSE_OFS_OV_ID: wb_dat_o <= {16'h0, `TSE_OV_ID_VAL};
				`TSE_OFS_OV_DATA: wb_dat_o <= ov_data;
				`TSE_OFS_OV_TLO: wb_dat_o <= ov_time[31:0];
				`TSE_OFS_OV_THI: wb_dat_o <= ov_time[63:32];
				`TSE_OFS_STAT: wb_dat_o <= {30'h0, stat};
				`TSE_OFS_MASK: wb_dat_o <= {30'h0, mask};
				`TSE_OFS_DIV: wb_dat_o <= div;
				default: wb_dat_o <= 32'h0; // ctrl is write-only
			endcase
		end
	end

	// latch copies exactly the pre-edge count
	property p_latch;
		@(posedge clk_i) disable iff (rst_i)
		(wr_hit && wb_adr_i == `TSE_OFS_CTRL && wb_sel_i[0] && wb_dat_i[0])
		|=> snapshot == $past(count);
	endproperty
	a_latch: assert property (p_latch) else $error("snapshot not latched");

	// clear zeroes counter next cycle
	property p_clear;
		@(posedge clk_i) disable iff (rst_i)
		(wr_hit && wb_adr_i == `TSE_OFS_CTRL && wb_sel_i[0] && wb_dat_i[1])
		|=> count == 64'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared");

	// counter step on tick
	property p_step;
		@(posedge clk_i) disable iff (rst_i)
		(tick && !(wr_hit && wb_adr_i == `TSE_OFS_CTRL && wb_sel_i[0] && wb_dat_i[1]))
		|=> count == $past(count) + 64'h1;
	endproperty
	a_step: assert property (p_step) else $error("counter did not step");

	// no movement without tick or clear
	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		(!tick && !wr_hit) |=> $stable(count);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved");

	// pulse stamp and sticky bit
	property p_p6;
		@(posedge clk_i) disable iff (rst_i)
		pulse6_i |=> (p6_time == $past(count)) && stat[0];
	endproperty
	a_p6: assert property (p_p6) else $error("line six capture wrong");

	// overflow stamp and sticky bit
	property p_ov;
		@(posedge clk_i) disable iff (rst_i)
		ovf_i |=> (ov_time == $past(count)) && stat[1] && ov_data == $past(ovf_data_i);
	endproperty
	a_ov: assert property (p_ov) else $error("overflow capture wrong");

	// line six data captured
	property p_p6d;
		@(posedge clk_i) disable iff (rst_i)
		pulse6_i |=> p6_data == $past(pulse6_data_i);
	endproperty
	a_p6d: assert property (p_p6d) else $error("line six data wrong");

	// ack lasts one cycle then drops for two
	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		$rose(wb_ack_o) |=> !wb_ack_o [*2];
	endproperty
	a_ack: assert property (p_ack) else $error("ack too long");

	// interrupt follows masked overflow status
	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		(stat[1] && mask[1]) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	// irq is the masked status of the cycle before, in both directions
	property p_irq_lvl;
		@(posedge clk_i) disable iff (rst_i)
		irq_o == $past(|(stat & mask));
	endproperty
	a_irq_lvl: assert property (p_irq_lvl) else $error("irq level wrong");

	// ack only ever answers a request
	property p_ack_req;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");

	// snapshot low word reaches the bus
	property p_rd_lo;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && wb_adr_i == `TSE_OFS_SNAP_LO) |=> wb_dat_o == $past(snapshot[31:0]);
	endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("snapshot low read wrong");

	// snapshot high word reaches the bus
	property p_rd_hi;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && wb_adr_i == `TSE_OFS_SNAP_HI) |=> wb_dat_o == $past(snapshot[63:32]);
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("snapshot high read wrong");

	// line six id is a constant, never a captured value
	property p_rd_p6id;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && wb_adr_i == `TSE_OFS_P6_ID) |=> wb_dat_o == {16'h0, `TSE_P6_ID_VAL};
	endproperty
	a_rd_p6id: assert property (p_rd_p6id) else $error("line six id wrong");

	// overflow id is a constant of its own
	property p_rd_ovid;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && wb_adr_i == `TSE_OFS_OV_ID) |=> wb_dat_o == {16'h0, `TSE_OV_ID_VAL};
	endproperty
	a_rd_ovid: assert property (p_rd_ovid) else $error("overflow id wrong");

	// line six capture holds between pulses
	property p_p6_keep;
		@(posedge clk_i) disable iff (rst_i)
		!pulse6_i |=> $stable(p6_time) && $stable(p6_data);
	endproperty
	a_p6_keep: assert property (p_p6_keep) else $error("line six capture moved");

	// overflow capture holds between events
	property p_ov_keep;
		@(posedge clk_i) disable iff (rst_i)
		!ovf_i |=> $stable(ov_time) && $stable(ov_data);
	endproperty
	a_ov_keep: assert property (p_ov_keep) else $error("overflow capture moved");

	// write one clears the line six bit when no pulse arrives
	property p_stat_w1c;
		@(posedge clk_i) disable iff (rst_i)
		(stat_clr[0] && !pulse6_i) |=> !stat[0];
	endproperty
	a_stat_w1c: assert property (p_stat_w1c) else $error("status not cleared");

	// snapshot only moves on a write
	property p_snap_keep;
		@(posedge clk_i) disable iff (rst_i)
		!wr_hit |=> $stable(snapshot);
	endproperty
	a_snap_keep: assert property (p_snap_keep) else $error("snapshot moved");
endmodule // tse_top

// File: verif/tse_top_bench.sv
// self-checking bench for the timestamp/event block
// assumes the block answers classic wishbone and samples event pulses at clk_i
`timescale 1ns/1ns
`include "tse_map.svh"
module tse_top_bench;
	import tse_pkg::*;
	logic clk_i = 1'b0; // 250 MHz system clock
	logic rst_i = 1'b1; // sync reset, held 20 cycles
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, p6 = 1'b0, ov = 1'b0; // bus and event strobes
	logic [7:0] adr = 8'h00; // byte address
	logic [3:0] sel = 4'hf; // all lanes unless a scenario narrows it
	logic [31:0] wdat = 32'h0, p6d = 32'h0, ovd = 32'h0, rd, t0; // data and captures
	logic [31:0] dat_o; // read data from the block
	logic ack, irq; // answer and interrupt
	int miscompares = 0;
	int n_tests = 0;
	`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
		$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

	// clock, half period 2 ns
	always #2 clk_i = ~clk_i;

	tse_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.pulse6_i(p6), .pulse6_data_i(p6d), .ovf_i(ov), .ovf_data_i(ovd), .irq_o(irq));

	// one classic cycle; holds everything until ack is seen, then idles one cycle
	// waits as long as it takes: only the watchdog ends a hung cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	// read and compare in one go
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	// line six pulse, then overflow gap cycles later; stamps differ by the ticks between
	task automatic ev2(input int gap, input logic [31:0] d6, input logic [31:0] dv);
		p6 <= 1'b1;
		p6d <= d6;
		@(posedge clk_i);
		p6 <= 1'b0;
		repeat (gap - 1) @(posedge clk_i);
		ov <= 1'b1;
		ovd <= dv;
		@(posedge clk_i);
		ov <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	// stamp difference ov minus p6; the count stays small, so both high words are zero
	task automatic stamp_diff(input logic [31:0] e);
		bus(1'b0, `TSE_OFS_P6_TLO, 32'h0);
		t0 = rd;
		bus(1'b0, `TSE_OFS_OV_TLO, 32'h0);
		`CHK(rd - t0, e)
		rdc(`TSE_OFS_P6_THI, 32'h0);
		rdc(`TSE_OFS_OV_THI, 32'h0);
	endtask

	// tick rate follows divider; write-only and unmapped places read zero
	task automatic t_rate;
		rdc(`TSE_OFS_RATE, `TSE_CLK_HZ);
		bus(1'b1, `TSE_OFS_DIV, 32'h1);
		rdc(`TSE_OFS_RATE, 32'h07735940);
		// only the low lane of the divider may change: divide by four
		sel <= 4'h1;
		bus(1'b1, `TSE_OFS_DIV, 32'hffffff03);
		sel <= 4'hf;
		rdc(`TSE_OFS_RATE, 32'h03b9aca0);
		rdc(`TSE_OFS_CTRL, 32'h0);
		rdc(8'h3c, 32'h0);
	endtask

	// divider stalls ticks, so clear then latch must give exactly zero
	task automatic t_clear_latch;
		bus(1'b1, `TSE_OFS_DIV, 32'hffffffff);
		bus(1'b1, `TSE_OFS_CTRL, 32'h2);
		bus(1'b1, `TSE_OFS_CTRL, 32'h1);
		rdc(`TSE_OFS_SNAP_LO, 32'h0);
		rdc(`TSE_OFS_SNAP_HI, 32'h0);
	endtask

	// ids, data, stamps and interrupt with a tick every cycle
	task automatic t_events;
		bus(1'b1, `TSE_OFS_DIV, 32'h0);
		bus(1'b1, `TSE_OFS_MASK, 32'h3);
		// clear acks at edge c, latch acks at c+3: two ticks between them
		bus(1'b1, `TSE_OFS_CTRL, 32'h2);
		bus(1'b1, `TSE_OFS_CTRL, 32'h1);
		rdc(`TSE_OFS_SNAP_LO, 32'h2);
		ev2(5, 32'ha5a5_0001, 32'h5a5a_0002);
		`CHK(irq, 1'b1)
		rdc(`TSE_OFS_P6_ID, {16'h0, `TSE_P6_ID_VAL});
		rdc(`TSE_OFS_P6_DATA, 32'ha5a5_0001);
		rdc(`TSE_OFS_OV_ID, {16'h0, `TSE_OV_ID_VAL});
		rdc(`TSE_OFS_OV_DATA, 32'h5a5a_0002);
		stamp_diff(32'h5);
		rdc(`TSE_OFS_STAT, 32'h3);
		bus(1'b1, `TSE_OFS_STAT, 32'h3);
		repeat (2) @(posedge clk_i);
		`CHK(irq, 1'b0)
		rdc(`TSE_OFS_STAT, 32'h0);
	endtask

	// masked event stays quiet; divider of 3 gives two ticks over eight cycles
	task automatic t_mask_div;
		bus(1'b1, `TSE_OFS_MASK, 32'h0);
		bus(1'b1, `TSE_OFS_DIV, 32'h3);
		ev2(8, 32'h1, 32'h2);
		`CHK(irq, 1'b0)
		stamp_diff(32'h2);
		bus(1'b1, `TSE_OFS_MASK, 32'h1);
		repeat (2) @(posedge clk_i);
		`CHK(irq, 1'b1)
	endtask

	// verdict and end of run
	task report_and_stop;
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_rate();
		t_clear_latch();
		t_events();
		t_mask_div();
		report_and_stop();
	end

	// hang guard, far beyond the roughly 150 cycles the tests need
	initial begin
		#40000;
		miscompares++;
		report_and_stop();
	end
endmodule // tse_top_bench
